// [src/buck_command_limits_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "buck_regs_defines.svh"
module buck_command_limits_regs (
  input  wire logic                     clk_sys,      // 10 MHz system clock
  input  wire logic                     rstn,         // Async reset, active low
  input  wire buck_regs_pkg::reg_req_t  req,          // Register access from I2C
  output var  logic [7:0]               rdata,        // Read data of addressed register
  input  wire logic                     modeSignal,   // Internal mode signal
  input  wire logic                     rampActive,   // Voltage ramp in progress
  input  wire logic                     selectPin,    // Voltage select pin level
  input  wire logic                     faultEvent,   // Thermal shutdown or short circuit pulse
  input  wire logic [7:0]               dieTempC,     // Sensed die temperature
  output var  buck_regs_pkg::ctrl_out_t ctrl,         // Decoded controls
  output var  logic                     restartPulse, // Start new power-up sequence
  output var  logic                     thermalWarn   // Pre-warning flag
);
  import buck_regs_pkg::*;

  logic [7:0] modeCtl_r;
  logic [7:0] limits_r;
  logic [7:0] levelLow_r;
  logic       force_register_reset;

  function automatic logic [7:0] warnTemp(input logic [1:0] code);
    unique case (code)
      2'b00: warnTemp = `TWARN_83C;
      2'b01: warnTemp = `TWARN_94C;
      2'b10: warnTemp = `TWARN_105C;
      2'b11: warnTemp = `TWARN_116C;
    endcase
  endfunction

  function automatic logic [12:0] inductor_current_limit(input logic [1:0] code);
    unique case (code)
      2'b00: inductor_current_limit = `INDUCTOR_CURRENT_LIMIT_5200MA;
      2'b01: inductor_current_limit = `INDUCTOR_CURRENT_LIMIT_5800MA;
      2'b10: inductor_current_limit = `INDUCTOR_CURRENT_LIMIT_6200MA;
      2'b11: inductor_current_limit = `INDUCTOR_CURRENT_LIMIT_6800MA;
    endcase
  endfunction

  // Force-reset is never stored, so it reads back 0 and acts as a one-shot
  assign force_register_reset = req.writeEn && (req.addr == `ADDR_LIMITS_CONFIG)
                    && req.wdata[`LIM_FORCE_BIT];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modeCtl_r <= `MODE_CONTROL_RESET;
    end else if (force_register_reset) begin
      modeCtl_r <= `MODE_CONTROL_RESET;
    end else if (req.writeEn && req.addr == `ADDR_MODE_CONTROL) begin
      modeCtl_r <= req.wdata & `MODE_CONTROL_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      levelLow_r <= `LEVEL_SEL_LOW_RESET;
    end else if (force_register_reset) begin
      levelLow_r <= `LEVEL_SEL_LOW_RESET;
    end else if (req.writeEn && req.addr == `ADDR_LEVEL_SEL_LOW) begin
      levelLow_r <= req.wdata;
    end
  end

  // Reset value carries the indicator at 1; host writes 0 to acknowledge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      limits_r <= `LIMITS_CONFIG_RESET;
    end else if (force_register_reset) begin
      limits_r <= `LIMITS_CONFIG_RESET;
    end else if (req.writeEn && req.addr == `ADDR_LIMITS_CONFIG) begin
      limits_r <= req.wdata & `LIMITS_CONFIG_MASK & ~(8'h01 << `LIM_FORCE_BIT);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      unique case (req.addr)
        `ADDR_MODE_CONTROL:  rdata <= modeCtl_r;
        `ADDR_LIMITS_CONFIG: rdata <= limits_r;
        `ADDR_LEVEL_SEL_LOW: rdata <= levelLow_r;
        default:             rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '0;
    end else begin
      if (rampActive) begin
        ctrl.forcedPwm <= modeCtl_r[`MODE_RAMP_BIT];
      end else if (modeSignal) begin
        ctrl.forcedPwm <= modeCtl_r[`MODE_SIGHIGH_BIT];
      end else begin
        ctrl.forcedPwm <= modeCtl_r[`MODE_SIGLOW_BIT];
      end
      ctrl.autoRestart   <= limits_r[`LIM_AUTO_RESTART_AFTER_FAULT_BIT];
      ctrl.warnTempC     <= warnTemp(limits_r[`LIM_TWARN_LSB +: 2]);
      ctrl.ipeakMa       <= inductor_current_limit(limits_r[`LIM_INDUCTOR_CURRENT_LIMIT_LSB +: 2]);
      ctrl.levelFromCode <= modeCtl_r[`MODE_GATING_BIT] && !selectPin;
      ctrl.levelUv       <= `LEVEL_BASE_UV + 21'(levelLow_r[6:0]) * `LEVEL_STEP_UV;
    end
  end

  // Restart keeps programmed registers; only a pulse goes to the sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      restartPulse <= 1'b0;
    end else begin
      restartPulse <= faultEvent && limits_r[`LIM_AUTO_RESTART_AFTER_FAULT_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      thermalWarn <= 1'b0;
    end else begin
      thermalWarn <= dieTempC >= warnTemp(limits_r[`LIM_TWARN_LSB +: 2]);
    end
  end
endmodule
`default_nettype wire

// [src/buck_regs_defines.svh]
`ifndef BUCK_REGS_DEFINES_SVH
`define BUCK_REGS_DEFINES_SVH
`define ADDR_MODE_CONTROL   8'h14
`define ADDR_LIMITS_CONFIG  8'h16
`define ADDR_LEVEL_SEL_LOW  8'h11
`define MODE_GATING_BIT     0
`define MODE_RAMP_BIT       5
`define MODE_SIGHIGH_BIT    6
`define MODE_SIGLOW_BIT     7
`define LIM_AUTO_RESTART_AFTER_FAULT_BIT       0
`define LIM_RSTIND_BIT      1
`define LIM_FORCE_BIT       2
`define LIM_TWARN_LSB       4
`define LIM_INDUCTOR_CURRENT_LIMIT_LSB       6
`define MODE_CONTROL_RESET  8'h00
`define LIMITS_CONFIG_RESET 8'h02
`define LEVEL_SEL_LOW_RESET 8'h00
`define MODE_CONTROL_MASK   8'hE1
`define LIMITS_CONFIG_MASK  8'hF7
`define TWARN_83C           8'd83
`define TWARN_94C           8'd94
`define TWARN_105C          8'd105
`define TWARN_116C          8'd116
`define INDUCTOR_CURRENT_LIMIT_5200MA        13'd5200
`define INDUCTOR_CURRENT_LIMIT_5800MA        13'd5800
`define INDUCTOR_CURRENT_LIMIT_6200MA        13'd6200
`define INDUCTOR_CURRENT_LIMIT_6800MA        13'd6800
`define LEVEL_BASE_UV       21'd600000
`define LEVEL_STEP_UV       21'd6250
`endif

// [src/buck_regs_pkg.sv]
package buck_regs_pkg;
  typedef struct packed {
    logic       writeEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic       forcedPwm;
    logic       autoRestart;
    logic [7:0] warnTempC;
    logic [12:0] ipeakMa;
    logic [20:0] levelUv;
    logic       levelFromCode;
  } ctrl_out_t;
endpackage

// [test/buck_regs_props.sv]
`timescale 1ns/100ps
`default_nettype none
module buck_regs_props (
  input wire logic clk_sys, rstn, modeSignal, rampActive, selectPin, faultEvent, restartPulse, thermalWarn,
  input wire logic [7:0] dieTempC, rdata,
  input wire buck_regs_pkg::reg_req_t req,
  input wire buck_regs_pkg::ctrl_out_t ctrl
);
  import buck_regs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire lim = req.writeEn && req.addr == 8'h16;
  a_fault_restart: assert property (faultEvent && ctrl.autoRestart |=> restartPulse)
    else $error("no restart");
  a_quiet_restart: assert property (!faultEvent |=> !restartPulse) else $error("stray restart");
  a_auto_restart_after_fault_copy: assert property (lim && !req.wdata[2] |-> ##2 ctrl.autoRestart == $past(req.wdata[0], 2))
    else $error("auto_restart_after_fault lost");
  a_force_default: assert property (lim && req.wdata[2] |-> ##2 ctrl.ipeakMa == 13'd5200 &&
    ctrl.warnTempC == 8'd83 && !ctrl.autoRestart) else $error("no default");
  // Top and bottom thresholds hold whatever the setting, so no register view is needed
  a_warn_hot: assert property (dieTempC >= 8'd116 |=> thermalWarn) else $error("warn missing");
  a_warn_cool: assert property ($past(rstn) && dieTempC < 8'd83 |=> !thermalWarn)
    else $error("warn stray");
  a_peak_legal: assert property ($past(rstn) |-> ctrl.ipeakMa inside {13'd5200, 13'd5800, 13'd6200, 13'd6800})
    else $error("bad peak");
  a_level_step: assert property (ctrl.levelFromCode |-> (ctrl.levelUv - 21'd600000) % 21'd6250 == 0)
    else $error("bad level");
  cover property (restartPulse);
  cover property (thermalWarn);
  cover property (ctrl.levelFromCode);
endmodule
bind buck_command_limits_regs buck_regs_props buck_regs_props_i (.clk_sys, .rstn, .modeSignal, .rampActive,
  .selectPin, .faultEvent, .restartPulse, .thermalWarn, .dieTempC, .rdata, .req, .ctrl);
`default_nettype wire

// [test/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                    clk_sys, // Bus clock
  input  wire logic [7:0]              rdata,   // Read data
  output var  buck_regs_pkg::reg_req_t req      // Request to device
);
  import buck_regs_pkg::*;
  initial req = '0;
  // Data is inverted once released so a stale value can never pass for a fresh one
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys) req <= {1'b1, a, d};
    @(negedge clk_sys) req <= {1'b0, a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys) req.addr <= a;
    @(negedge clk_sys) q = rdata;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import buck_regs_pkg::*;
  logic clk_sys = 0, rstn = 0, modeSignal = 0, rampActive = 0, selectPin = 0, faultEvent = 0, restartPulse, thermalWarn, b;
  logic [7:0] dieTempC = 0, rdata, q;
  reg_req_t req;
  ctrl_out_t ctrl;
  int miscompares = 0, tests_run = 0, cyc = 0;
  logic [7:0] rows [5][3] = '{'{8'h14, 8'hFF, 8'hE1}, '{8'h16, 8'hF9, 8'hF1}, '{8'h16, 8'h0B, 8'h03},
    '{8'h11, 8'hFF, 8'hFF}, '{8'h20, 8'hAA, 8'h00}};
  logic [7:0] tw [4] = '{8'd83, 8'd94, 8'd105, 8'd116};
  logic [12:0] ip [4] = '{13'd5200, 13'd5800, 13'd6200, 13'd6800};
  buck_command_limits_regs buck_command_limits_regs_i (.clk_sys, .rstn, .req, .rdata, .modeSignal,
    .rampActive, .selectPin, .faultEvent, .dieTempC, .ctrl, .restartPulse, .thermalWarn);
  host_model host_model_i (.clk_sys, .rdata, .req);
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1500) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1;
    foreach (rows[i]) begin
      host_model_i.wr(rows[i][0], rows[i][1]);
      host_model_i.rd(rows[i][0], q);
      chk(q, rows[i][2]);
    end
    chk(ctrl.levelUv, 21'd1393750);
    $display("rows done");
    rstn = 0;
    @(negedge clk_sys) rstn = 1;
    host_model_i.rd(8'h16, q);
    chk({q, ctrl.ipeakMa, ctrl.warnTempC}, {8'h02, 13'd5200, 8'd83});
    $display("reset done");
    for (int r = 0; r < 2; r++) begin
      host_model_i.wr(8'h16, r[7:0]);
      repeat (2) @(negedge clk_sys);
      faultEvent = 1;
      @(negedge clk_sys) faultEvent = 0;
      chk({restartPulse, ctrl.autoRestart}, {r[0], r[0]});
    end
    $display("fault done");
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr(8'h16, {i[1:0], i[1:0], 4'h0});
      dieTempC = tw[i] - 8'd1;
      repeat (3) @(negedge clk_sys);
      b = thermalWarn;
      dieTempC = tw[i];
      repeat (2) @(negedge clk_sys);
      chk({b, thermalWarn, ctrl.ipeakMa, ctrl.warnTempC}, {2'b01, ip[i], tw[i]});
    end
    $display("limits done");
    for (int j = 0; j < 8; j++) begin
      host_model_i.wr(8'h14, {j[2:0], 5'h00});
      for (int k = 0; k < 4; k++) begin
        {rampActive, modeSignal} = k[1:0];
        repeat (3) @(negedge clk_sys);
        chk(ctrl.forcedPwm, k[1] ? j[0] : k[0] ? j[1] : j[2]);
      end
    end
    $display("modes done");
    host_model_i.wr(8'h14, 8'h01);
    selectPin = 0;
    repeat (2) @(negedge clk_sys);
    chk({ctrl.levelFromCode, ctrl.levelUv}, {1'b1, 21'd600000});
    selectPin = 1;
    repeat (2) @(negedge clk_sys);
    chk(ctrl.levelFromCode, 1'b0);
    $display("gating done");
    host_model_i.wr(8'h16, 8'hF5);
    host_model_i.rd(8'h16, q);
    chk(q, 8'h02);
    host_model_i.rd(8'h14, q);
    chk(q, 8'h00);
    $display("force reset done");
    close_out;
  end
endmodule
`default_nettype wire
